// ---- wte_pkg.sv ----
package wte_pkg;

	// ------------------------------------------------------------
	// Register indices; the byte address is four times the index.
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_CONTROL_C_REGISTER = 6'h02; // Output source select and override enable.
	localparam logic [5:0] IDX_CONTROL_D_REGISTER = 6'h03; // Override values per phase.
	localparam logic [5:0] IDX_EVCTRLA = 6'h08; // Input A detection and capture control.
	localparam logic [5:0] IDX_EVCTRLB = 6'h09; // Input B detection and capture control.
	localparam logic [5:0] IDX_INTEN = 6'h0c; // Interrupt enables.
	localparam logic [5:0] IDX_INTERRUPT_FLAG_REGISTER = 6'h0d; // Interrupt flags, write one to clear.
	localparam logic [5:0] IDX_STATUS = 6'h0e; // Run and fault state, read only.
	localparam logic [5:0] IDX_FAULT_OUTPUT_CONTROL = 6'h12; // Output enables and fault values.
	localparam logic [5:0] IDX_DELAY_CONTROL = 6'h14; // Delay source, trigger and prescaler.
	localparam logic [5:0] IDX_DELAY_VALUE = 6'h15; // Delay count.
	localparam logic [5:0] IDX_DEBUG_CONTROL = 6'h1e; // Debug run and debug fault.

	// ------------------------------------------------------------
	// Field positions.
	// ------------------------------------------------------------
	localparam int BIT_OVR = 0; // Override enable in CONTROL_C_REGISTER.
	localparam int BIT_CSEL = 6; // Output C source select in CONTROL_C_REGISTER.
	localparam int BIT_DSEL = 7; // Output D source select in CONTROL_C_REGISTER.
	localparam int BIT_EV_CAPT = 2; // Capture on event in EVCTRLx.
	localparam int BIT_EV_EDGE = 4; // Edge detection in EVCTRLx.
	localparam int BIT_OVF = 0; // Cycle end flag position.
	localparam int BIT_TRIGGER_FLAG_A = 2; // Trigger flag A position.
	localparam int BIT_TRIGGER_FLAG_B = 3; // Trigger flag B position.
	localparam int BIT_DEBUG_RUN_BIT = 0; // Debug run bit.
	localparam int BIT_DEBUG_FAULT_BIT = 2; // Debug fault bit.

	// ------------------------------------------------------------
	// Reset values, counts and codes.
	// ------------------------------------------------------------
	localparam logic [7:0] RST_REG = 8'h00; // Common reset value.
	localparam logic [2:0] CCP_WINDOW = 3'h4; // Instructions the unlock stays open.
	localparam logic [1:0] DLY_OFF = 2'h0; // Delay hardware unused.
	localparam logic [1:0] DLY_BLANK = 2'h1; // Input blanking owns the delay hardware.
	localparam logic [1:0] DLY_EVENT = 2'h2; // Delayed programmable output event.
	localparam logic [1:0] SLP_STANDBY = 2'h2; // Standby sleep code.
	localparam logic [1:0] SLP_PDOWN = 2'h3; // Power-down sleep code.
	localparam logic [1:0] PH_DEAD_A = 2'h0; // Phase codes from the counter core.
	localparam logic [1:0] PH_ON_A = 2'h1;
	localparam logic [1:0] PH_DEAD_B = 2'h2;
	localparam logic [1:0] PH_ON_B = 2'h3;

endpackage : wte_pkg

// ---- wte_delay.sv ----
`timescale 1ns/100ps
`default_nettype none

// Programmable event: shares trigger and delay hardware with blanking.
module wte_delay import wte_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic trig_i,
	input wire logic [1:0] sel_i,
	input wire logic [1:0] presc_i,
	input wire logic [7:0] val_i,
	output logic ev_o
);

	logic busy_reg; // A delay is counting.
	logic [7:0] pre_reg; // Prescaler divides the synchronizer clock.
	logic [7:0] cnt_reg; // Delay clocks counted so far.
	logic tick; // One delay clock.

	// Division factor is 1, 2, 4 or 8 from the prescaler field.
	assign tick = (pre_reg == ((8'h01 << presc_i) - 8'h01));

	// ------------------------------------------------------------
	// Delay counter; a new trigger while counting is ignored.
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_reg <= 1'b0;
			pre_reg <= RST_REG;
			cnt_reg <= RST_REG;
			ev_o <= 1'b0;
		end else if (run_i) begin
			ev_o <= 1'b0;
			if (sel_i == DLY_BLANK) begin
				ev_o <= trig_i;
				busy_reg <= 1'b0;
			end else if (sel_i == DLY_EVENT) begin
				if (!busy_reg && trig_i) begin
					busy_reg <= (val_i != 8'h00);
					ev_o <= (val_i == 8'h00);
					pre_reg <= RST_REG;
					cnt_reg <= RST_REG;
				end else if (busy_reg) begin
					pre_reg <= tick ? 8'h00 : pre_reg + 8'h01;
					if (tick) begin
						cnt_reg <= cnt_reg + 8'h01;
						if (cnt_reg + 8'h01 == val_i) begin
							busy_reg <= 1'b0;
							ev_o <= 1'b1;
						end
					end
				end
			end else begin
				busy_reg <= 1'b0;
			end
		end
	end

endmodule : wte_delay
`default_nettype wire

// ---- wte_outmux.sv ----
`timescale 1ns/100ps
`default_nettype none

// Output value selection: counter, override or fault values.
module wte_outmux import wte_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic wave_a_i,
	input wire logic wave_b_i,
	input wire logic one_ramp_i,
	input wire logic [1:0] phase_i,
	input wire logic [7:0] control_c_register_i,
	input wire logic [7:0] control_d_register_i,
	input wire logic [7:0] fault_ctrl_i,
	input wire logic fault_i,
	output logic [3:0] out_o
);

	logic a_val; // Waveform A before fault handling.
	logic b_val; // Waveform B before fault handling.
	logic [3:0] src; // Per-output source before fault.

	// ------------------------------------------------------------
	// Override picks a value per phase instead of the counter.
	// ------------------------------------------------------------
	always_comb begin
		a_val = wave_a_i;
		b_val = wave_b_i;
		if (control_c_register_i[BIT_OVR]) begin
			if (one_ramp_i) begin
				a_val = (phase_i == PH_ON_A) ? control_d_register_i[1] : control_d_register_i[0];
				b_val = (phase_i == PH_ON_B) ? control_d_register_i[7] : control_d_register_i[6];
			end else begin
				a_val = control_d_register_i[{1'b0, phase_i}];
				b_val = control_d_register_i[{1'b1, phase_i}];
			end
		end
	end

	// C and D follow A or B
	assign src = {control_c_register_i[BIT_DSEL] ? b_val : a_val, control_c_register_i[BIT_CSEL] ? b_val : a_val,
		b_val, a_val};

	// ------------------------------------------------------------
	// Output flops; state freezes when the timer is stopped and no fault is present.
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_out
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					out_o[g] <= 1'b0;
				// A fault forces the outputs even while the timer is stopped.
				end else if (run_i || fault_i) begin
					out_o[g] <= fault_i ? fault_ctrl_i[g] : src[g];
				end
			end
		end
	endgenerate

endmodule : wte_outmux
`default_nettype wire

// ---- wte_top.sv ----
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none

module wte_top import wte_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic por_i,
	input wire logic [7:0] fuse_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ccp_unlock_i,
	input wire logic insn_i,
	input wire logic [1:0] sleep_i,
	input wire logic debug_halt_i,
	input wire logic wave_a_i,
	input wire logic wave_b_i,
	input wire logic one_ramp_i,
	input wire logic [1:0] phase_i,
	input wire logic a_set_match_i,
	input wire logic a_clear_match_i,
	input wire logic b_set_match_i,
	input wire logic b_clear_match_i,
	input wire logic cycle_end_i,
	input wire logic ev_a_i,
	input wire logic ev_b_i,
	output logic [3:0] wave_out_o,
	output logic [3:0] out_en_o,
	output logic fault_a_o,
	output logic fault_b_o,
	output logic capture_a_o,
	output logic capture_b_o,
	output logic a_set_ev_o,
	output logic b_set_ev_o,
	output logic b_clear_ev_o,
	output logic prog_ev_o,
	output logic timer_run_o,
	output logic irq_ovf_o,
	output logic irq_trig_o
);

	// ------------------------------------------------------------
	// Registers.
	// ------------------------------------------------------------
	logic [7:0] control_c_register; // Source select and override enable.
	logic [7:0] control_d_register; // Override values A low, B high nibble.
	logic [7:0] evctrl_a_reg; // Input A control.
	logic [7:0] evctrl_b_reg; // Input B control.
	logic [7:0] int_en_reg; // Interrupt enables.
	logic [7:0] int_flag_reg; // Sticky interrupt flags.
	logic [7:0] fault_output_control; // Enables high nibble, fault values low.
	logic [7:0] delay_control; // Prescaler, trigger and source select.
	logic [7:0] delay_value; // Delay count.
	logic [7:0] debug_control; // Debug run and debug fault.
	logic fuse_pend_reg; // Fuse load still owed after reset.
	logic [2:0] ccp_cnt_reg; // Instructions left in the unlock window.
	logic ack_reg; // Bus acknowledge.
	logic ev_a_q_reg; // Previous input A level.
	logic ev_b_q_reg; // Previous input B level.

	// ------------------------------------------------------------
	// Decoded control.
	// ------------------------------------------------------------
	logic run; // Timer advances this cycle.
	logic dbg_fault; // Debug-forced fault on both inputs.
	logic in_a; // Input A detected.
	logic in_b; // Input B detected.
	logic ev_a_rise; // Rising edge on input A.
	logic ev_b_rise; // Rising edge on input B.
	logic req; // A bus request is present.
	logic wr_go; // Write takes effect this edge.
	logic [5:0] idx; // Register index from the address.
	logic [7:0] set_flags; // Hardware events this cycle.
	logic [7:0] rd_data; // Read multiplexer.
	logic trig_sel; // Selected delay trigger.

	// Byte-lane write check shared by every register.
	function automatic logic wr_hit(input logic [5:0] a, input logic [5:0] target,
		input logic go, input logic lane);
		wr_hit = go && lane && (a == target);
	endfunction : wr_hit

	assign req = wb_cyc_i && wb_stb_i;
	assign idx = wb_adr_i[7:2];
	assign wr_go = req && wb_we_i && ack_reg;
	assign wb_ack_o = ack_reg;

	// ------------------------------------------------------------
	// Run control.
	// ------------------------------------------------------------
	// stopped in standby and power-down
	assign run = ce_i && (sleep_i != SLP_STANDBY) && (sleep_i != SLP_PDOWN)
		&& !(debug_halt_i && !debug_control[BIT_DEBUG_RUN_BIT]);
	assign timer_run_o = run;

	assign dbg_fault = debug_halt_i && debug_control[BIT_DEBUG_FAULT_BIT];
	assign ev_a_rise = ev_a_i && !ev_a_q_reg;
	assign ev_b_rise = ev_b_i && !ev_b_q_reg;

	assign in_a = evctrl_a_reg[BIT_EV_EDGE] ? ev_a_rise : ev_a_i;
	assign in_b = evctrl_b_reg[BIT_EV_EDGE] ? ev_b_rise : ev_b_i;

	// Previous input levels for the edge detectors.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ev_a_q_reg <= 1'b0;
			ev_b_q_reg <= 1'b0;
		end else if (ce_i) begin
			ev_a_q_reg <= ev_a_i;
			ev_b_q_reg <= ev_b_i;
		end
	end

	// ------------------------------------------------------------
	// Input and event strobes, registered; each follows its condition one cycle later.
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_a_o <= 1'b0;
			fault_b_o <= 1'b0;
			capture_a_o <= 1'b0;
			capture_b_o <= 1'b0;
			a_set_ev_o <= 1'b0;
			b_set_ev_o <= 1'b0;
			b_clear_ev_o <= 1'b0;
		end else if (ce_i) begin
			// debug fault holds while halted
			// The forced fault must survive a halted timer, or the safeguard is void.
			fault_a_o <= (run && in_a) || dbg_fault;
			fault_b_o <= (run && in_b) || dbg_fault;
			capture_a_o <= run && in_a && evctrl_a_reg[BIT_EV_CAPT];
			capture_b_o <= run && in_b && evctrl_b_reg[BIT_EV_CAPT];
			a_set_ev_o <= run && a_set_match_i;
			b_set_ev_o <= run && b_set_match_i;
			b_clear_ev_o <= run && b_clear_match_i;
		end
	end

	// ------------------------------------------------------------
	// Programmable output event.
	// ------------------------------------------------------------
	// any compare match, A clear included
	always_comb begin
		case (delay_control[3:2])
			2'h0: trig_sel = a_set_match_i;
			2'h1: trig_sel = a_clear_match_i;
			2'h2: trig_sel = b_set_match_i;
			2'h3: trig_sel = b_clear_match_i;
			default: trig_sel = 1'b0;
		endcase
	end

	wte_delay u_delay (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(run),
		.trig_i(trig_sel),
		.sel_i(delay_control[1:0]),
		.presc_i(delay_control[5:4]),
		.val_i(delay_value),
		.ev_o(prog_ev_o)
	);

	// ------------------------------------------------------------
	// Output path.
	// ------------------------------------------------------------
	wte_outmux u_outmux (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(run),
		.wave_a_i(wave_a_i),
		.wave_b_i(wave_b_i),
		.one_ramp_i(one_ramp_i),
		.phase_i(phase_i),
		.control_c_register_i(control_c_register),
		.control_d_register_i(control_d_register),
		.fault_ctrl_i(fault_output_control),
		.fault_i(ce_i && (fault_a_o || fault_b_o)),
		.out_o(wave_out_o)
	);

	assign out_en_o = fault_output_control[7:4];

	// ------------------------------------------------------------
	// Wishbone acknowledge: one wait cycle, dropped after one.
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else if (ce_i) begin
			ack_reg <= req && !ack_reg;
		end
	end

	// Read data; unmapped addresses read zero.
	always_comb begin
		case (idx)
			IDX_CONTROL_C_REGISTER: rd_data = control_c_register;
			IDX_CONTROL_D_REGISTER: rd_data = control_d_register;
			IDX_EVCTRLA: rd_data = evctrl_a_reg;
			IDX_EVCTRLB: rd_data = evctrl_b_reg;
			IDX_INTEN: rd_data = int_en_reg;
			IDX_INTERRUPT_FLAG_REGISTER: rd_data = int_flag_reg;
			IDX_STATUS: rd_data = {5'h00, ccp_cnt_reg != 3'h0, fault_a_o || fault_b_o, run};
			IDX_FAULT_OUTPUT_CONTROL: rd_data = fault_output_control;
			IDX_DELAY_CONTROL: rd_data = delay_control;
			IDX_DELAY_VALUE: rd_data = delay_value;
			IDX_DEBUG_CONTROL: rd_data = debug_control;
			default: rd_data = RST_REG;
		endcase
	end

	// Read data is sampled in the request cycle and held while ack is high.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i && req && !ack_reg) begin
			wb_dat_o <= {24'h00_0000, rd_data};
		end
	end

	// ------------------------------------------------------------
	// Plain control registers.
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control_c_register <= RST_REG;
			control_d_register <= RST_REG;
			evctrl_a_reg <= RST_REG;
			evctrl_b_reg <= RST_REG;
			int_en_reg <= RST_REG;
			delay_control <= RST_REG;
			delay_value <= RST_REG;
			debug_control <= RST_REG;
		end else if (ce_i) begin
			if (wr_hit(idx, IDX_CONTROL_C_REGISTER, wr_go, wb_sel_i[0])) begin
				control_c_register <= wb_dat_i[7:0];
			end
			if (wr_hit(idx, IDX_CONTROL_D_REGISTER, wr_go, wb_sel_i[0])) begin
				control_d_register <= wb_dat_i[7:0];
			end
			if (wr_hit(idx, IDX_EVCTRLA, wr_go, wb_sel_i[0])) begin
				evctrl_a_reg <= wb_dat_i[7:0];
			end
			if (wr_hit(idx, IDX_EVCTRLB, wr_go, wb_sel_i[0])) begin
				evctrl_b_reg <= wb_dat_i[7:0];
			end
			if (wr_hit(idx, IDX_INTEN, wr_go, wb_sel_i[0])) begin
				int_en_reg <= wb_dat_i[7:0];
			end
			if (wr_hit(idx, IDX_DELAY_CONTROL, wr_go, wb_sel_i[0])) begin
				delay_control <= wb_dat_i[7:0];
			end
			if (wr_hit(idx, IDX_DELAY_VALUE, wr_go, wb_sel_i[0])) begin
				delay_value <= wb_dat_i[7:0];
			end
			if (wr_hit(idx, IDX_DEBUG_CONTROL, wr_go, wb_sel_i[0])) begin
				debug_control <= wb_dat_i[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Unlock window: counts instructions after the key.
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ccp_cnt_reg <= 3'h0;
		end else if (ce_i) begin
			if (ccp_unlock_i) begin
				ccp_cnt_reg <= CCP_WINDOW;
			end else if (insn_i && ccp_cnt_reg != 3'h0) begin
				ccp_cnt_reg <= ccp_cnt_reg - 3'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Fault control. Non-power-on resets keep the old value, then
	// the fuse is loaded once in the first cycle after release.
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fuse_pend_reg <= 1'b1;
			if (por_i) begin
				fault_output_control <= RST_REG;
			end
		end else if (ce_i) begin
			fuse_pend_reg <= 1'b0;
			if (fuse_pend_reg) begin
				fault_output_control <= fuse_i;
			end else if (wr_hit(idx, IDX_FAULT_OUTPUT_CONTROL, wr_go, wb_sel_i[0])
				&& ccp_cnt_reg != 3'h0) begin
				fault_output_control <= wb_dat_i[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt flags. A hardware set wins over a clear.
	// ------------------------------------------------------------
	always_comb begin
		set_flags = RST_REG;
		set_flags[BIT_OVF] = run && cycle_end_i;
		set_flags[BIT_TRIGGER_FLAG_A] = run && in_a;
		set_flags[BIT_TRIGGER_FLAG_B] = run && in_b;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_flag_reg <= RST_REG;
		end else if (ce_i) begin
			if (wr_hit(idx, IDX_INTERRUPT_FLAG_REGISTER, wr_go, wb_sel_i[0])) begin
				int_flag_reg <= (int_flag_reg & ~wb_dat_i[7:0]) | set_flags;
			end else begin
				int_flag_reg <= int_flag_reg | set_flags;
			end
		end
	end

	assign irq_ovf_o = int_flag_reg[BIT_OVF] && int_en_reg[BIT_OVF];
	assign irq_trig_o = (int_flag_reg[BIT_TRIGGER_FLAG_A] && int_en_reg[BIT_TRIGGER_FLAG_A])
		|| (int_flag_reg[BIT_TRIGGER_FLAG_B] && int_en_reg[BIT_TRIGGER_FLAG_B]);

	// ------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------
	property p_capture_with_fault;
		@(posedge clk_i) disable iff (rst_i) capture_a_o |-> fault_a_o;
	endproperty
	a_capture_with_fault: assert property (p_capture_with_fault)
		else $error("capture without input action");

	property p_por_clear;
		@(posedge clk_i) (rst_i && por_i) |=> fault_output_control == 8'h00;
	endproperty
	a_por_clear: assert property (p_por_clear)
		else $error("power-on reset did not clear fault control");

	property p_fuse_load;
		@(posedge clk_i) disable iff (rst_i) (ce_i && fuse_pend_reg)
			|=> fault_output_control == $past(fuse_i);
	endproperty
	a_fuse_load: assert property (p_fuse_load)
		else $error("fuse value not loaded");

	property p_fault_force;
		@(posedge clk_i) disable iff (rst_i) (ce_i && (fault_a_o || fault_b_o))
			|=> wave_out_o == $past(fault_output_control[3:0]);
	endproperty
	a_fault_force: assert property (p_fault_force)
		else $error("fault values not forced");

	property p_match_pulse;
		@(posedge clk_i) disable iff (rst_i) (ce_i && run && a_set_match_i)
			|=> a_set_ev_o;
	endproperty
	a_match_pulse: assert property (p_match_pulse)
		else $error("match strobe missing");

	property p_stopped;
		@(posedge clk_i) disable iff (rst_i)
			(sleep_i == SLP_STANDBY || sleep_i == SLP_PDOWN
			|| (debug_halt_i && !debug_control[BIT_DEBUG_RUN_BIT])) |-> !run;
	endproperty
	a_stopped: assert property (p_stopped)
		else $error("timer runs while stopped");

	property p_dbg_fault;
		@(posedge clk_i) disable iff (rst_i) (ce_i && dbg_fault)
			|=> fault_a_o && fault_b_o;
	endproperty
	a_dbg_fault: assert property (p_dbg_fault)
		else $error("debug fault not on both inputs");

	sequence s_locked_write;
		wr_go && idx == IDX_FAULT_OUTPUT_CONTROL && ccp_cnt_reg == 3'h0 && !fuse_pend_reg && ce_i;
	endsequence
	property p_locked;
		@(posedge clk_i) disable iff (rst_i) s_locked_write
			|=> $stable(fault_output_control);
	endproperty
	a_locked: assert property (p_locked)
		else $error("locked fault control changed");

	property p_set_wins;
		@(posedge clk_i) disable iff (rst_i) (ce_i && run && cycle_end_i)
			|=> int_flag_reg[BIT_OVF];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("overflow flag lost");

	property p_irq;
		@(posedge clk_i) disable iff (rst_i)
			irq_trig_o == ((int_flag_reg[3:2] & int_en_reg[3:2]) != 2'h0);
	endproperty
	a_irq: assert property (p_irq)
		else $error("trigger request mismatch");

endmodule : wte_top
`default_nettype wire

// ---- wte_evnet.sv ----
`timescale 1ns/100ps
`default_nettype none
// Event network model: a rising request becomes a one-cycle match strobe.
module wte_evnet (
	input wire logic clk_i,
	input wire logic [3:0] req_i,
	output logic [3:0] match_o
);
	logic [3:0] req_reg; // Last request level, so a held request fires once.
	always_ff @(posedge clk_i) begin
		req_reg <= req_i;
		match_o <= req_i & ~req_reg;
	end
endmodule : wte_evnet
`default_nettype wire

// ---- waveform_timer_output_events_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module waveform_timer_output_events_tb_top;
	import wte_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, config_change_protection = 1'b0, insn = 1'b0;
	logic halt = 1'b0, ramp = 1'b0, cend = 1'b0, eva = 1'b0, ack, prg, fa, fb, io, it, ase;
	logic bse, bce, cap, capb, runo, por = 1'b1;
	logic [7:0] adr = 8'h00, dat = 8'h00;
	logic [1:0] ph = 2'h0;
	logic [1:0] slp = 2'h0;
	logic [3:0] req = 4'h0, m, wo, en;
	logic [31:0] rd, q;
	int errors = 0, n_checks = 0;
	always #10 clk_i = ~clk_i;
	wte_evnet u_wte_evnet (.clk_i(clk_i), .req_i(req), .match_o(m));
	wte_top u_wte_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .por_i(por),
		.fuse_i(8'hf5), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i({24'h0, dat}), .wb_dat_o(rd), .wb_ack_o(ack),
		.ccp_unlock_i(config_change_protection), .insn_i(insn), .sleep_i(slp), .debug_halt_i(halt),
		.wave_a_i(ph[0]), .wave_b_i(ph[1]), .one_ramp_i(ramp), .phase_i(ph),
		.a_set_match_i(m[0]), .a_clear_match_i(m[1]), .b_set_match_i(m[2]),
		.b_clear_match_i(m[3]), .cycle_end_i(cend), .ev_a_i(eva), .ev_b_i(eva),
		.wave_out_o(wo), .out_en_o(en), .fault_a_o(fa), .fault_b_o(fb), .capture_a_o(cap),
		.capture_b_o(capb), .a_set_ev_o(ase), .b_set_ev_o(bse), .b_clear_ev_o(bce),
		.prog_ev_o(prg), .timer_run_o(runo), .irq_ovf_o(io), .irq_trig_o(it));
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One classic bus cycle; the wait for ack is bounded.
	task automatic wb(input logic w, input logic [5:0] ix, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= {ix, 2'h0};
		dat <= d;
		// Ack is judged at the rising edge itself, where the write lands.
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rd;
		cyc <= 1'b0;
		if (n >= 20) begin
			errors++;
			finish_test();
		end
	endtask : wb
	// Unlock, then let k instructions retire.
	task automatic unlock(input int k);
		@(posedge clk_i) config_change_protection <= 1'b1;
		@(posedge clk_i) config_change_protection <= 1'b0;
		repeat (k) begin
			@(posedge clk_i) insn <= 1'b1;
			@(posedge clk_i) insn <= 1'b0;
		end
	endtask : unlock
	// Fire one match and count cycles until the watched strobe shows.
	task automatic fire(input logic [3:0] r, input logic [1:0] p, output int n);
		logic [3:0] s;
		@(posedge clk_i) req <= r;
		repeat (2) @(posedge clk_i);
		req <= 4'h0;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
			s = {prg, bce, bse, ase};
		end while (s[p] !== 1'b1 && n < 60);
		if (n >= 60) begin
			errors++;
			finish_test();
		end
	endtask : fire
	task automatic t_prot;
		wb(1'b1, IDX_FAULT_OUTPUT_CONTROL, 8'h3a);
		wb(1'b0, IDX_FAULT_OUTPUT_CONTROL, 8'h00);
		chk(q, 32'hf5);
		unlock(4);
		wb(1'b1, IDX_FAULT_OUTPUT_CONTROL, 8'h3a);
		wb(1'b0, IDX_FAULT_OUTPUT_CONTROL, 8'h00);
		chk(q, 32'hf5);
		unlock(0);
		wb(1'b1, IDX_FAULT_OUTPUT_CONTROL, 8'hfa);
		wb(1'b0, IDX_FAULT_OUTPUT_CONTROL, 8'h00);
		chk(q, 32'hfa);
		$display("done protection");
	endtask : t_prot
	task automatic t_over;
		ramp <= 1'b1;
		ph <= PH_ON_A;
		wb(1'b1, IDX_CONTROL_D_REGISTER, 8'h02);
		wb(1'b1, IDX_CONTROL_C_REGISTER, 8'h01);
		repeat (2) @(negedge clk_i);
		chk(wo, 4'hd);
		wb(1'b1, IDX_CONTROL_C_REGISTER, 8'hc1);
		repeat (2) @(negedge clk_i);
		chk(wo, 4'h1);
		@(posedge clk_i);
		ramp <= 1'b0;
		ph <= PH_ON_B;
		wb(1'b1, IDX_CONTROL_D_REGISTER, 8'hd8);
		wb(1'b1, IDX_CONTROL_C_REGISTER, 8'h81);
		repeat (2) @(negedge clk_i);
		chk(wo, 4'hf);
		$display("done override");
	endtask : t_over
	task automatic t_events;
		logic [7:0] dc [4] = '{8'h16, 8'h16, 8'h15, 8'h36};
		logic [7:0] dv [4] = '{8'h03, 8'h00, 8'h03, 8'h02};
		int ex [4] = '{7, 1, 1, 17};
		int n;
		fire(4'h1, 2'd0, n);
		chk(n, 1);
		@(negedge clk_i);
		chk(ase, 1'b0);
		fire(4'h4, 2'd1, n);
		chk(n, 1);
		fire(4'h8, 2'd2, n);
		chk(n, 1);
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, IDX_DELAY_CONTROL, dc[i]);
			wb(1'b1, IDX_DELAY_VALUE, dv[i]);
			fire(4'h2, 2'd3, n);
			chk(n, ex[i]);
			@(negedge clk_i);
			chk(prg, 1'b0);
		end
		$display("done events");
	endtask : t_events
	task automatic t_irq;
		wb(1'b1, IDX_INTEN, 8'h0d);
		@(posedge clk_i) cend <= 1'b1;
		@(posedge clk_i) cend <= 1'b0;
		repeat (2) @(negedge clk_i);
		chk(io, 1'b1);
		wb(1'b1, IDX_INTERRUPT_FLAG_REGISTER, 8'h01);
		@(negedge clk_i);
		chk(io, 1'b0);
		@(posedge clk_i) eva <= 1'b1;
		@(posedge clk_i) eva <= 1'b0;
		repeat (2) @(negedge clk_i);
		chk(it, 1'b1);
		wb(1'b0, IDX_INTERRUPT_FLAG_REGISTER, 8'h00);
		chk(q, 32'h0c);
		wb(1'b1, IDX_INTERRUPT_FLAG_REGISTER, 8'h0c);
		@(negedge clk_i);
		chk(it, 1'b0);
		$display("done interrupts");
	endtask : t_irq
	task automatic t_fault;
		wb(1'b1, IDX_DEBUG_CONTROL, 8'h05);
		@(posedge clk_i) halt <= 1'b1;
		repeat (3) @(negedge clk_i);
		chk({fa, fb}, 2'h3);
		chk(wo, 4'ha);
		chk(en, 4'hf);
		wb(1'b1, IDX_DEBUG_CONTROL, 8'h04);
		repeat (2) @(negedge clk_i);
		chk({fa, fb, runo}, 3'h6);
		@(posedge clk_i) halt <= 1'b0;
		slp <= SLP_STANDBY;
		@(negedge clk_i);
		chk(runo, 1'b0);
		@(posedge clk_i) slp <= SLP_PDOWN;
		@(negedge clk_i);
		chk(runo, 1'b0);
		@(posedge clk_i) slp <= 2'h1;
		@(negedge clk_i);
		chk(runo, 1'b1);
		$display("done fault");
	endtask : t_fault
	// Input A on edges, input B on levels, both capturing; one held event.
	task automatic t_edge;
		int c;
		int cb;
		c = 0;
		cb = 0;
		wb(1'b1, IDX_EVCTRLA, 8'h14);
		wb(1'b1, IDX_EVCTRLB, 8'h04);
		@(posedge clk_i) eva <= 1'b1;
		repeat (4) begin
			@(negedge clk_i);
			c += cap;
			cb += capb;
		end
		@(posedge clk_i) eva <= 1'b0;
		chk(c, 1);
		chk(cb, 3);
		$display("done edges");
	endtask : t_edge
	// A reset that is not power-on keeps fault control, then reloads the fuse.
	task automatic t_rst;
		@(posedge clk_i);
		por <= 1'b0;
		rst_i <= 1'b1;
		repeat (3) @(negedge clk_i);
		chk(en, 4'hf);
		@(posedge clk_i) rst_i <= 1'b0;
		wb(1'b0, IDX_FAULT_OUTPUT_CONTROL, 8'h00);
		chk(q, 32'hf5);
		$display("done reset");
	endtask : t_rst
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(negedge clk_i);
		chk(en, 4'hf);
		t_prot();
		t_over();
		t_events();
		t_irq();
		t_edge();
		t_fault();
		t_rst();
		finish_test();
	end
endmodule : waveform_timer_output_events_tb_top
`default_nettype wire
